// File: logic/pic_params.svh
// offsets, field positions, reset values and timing counts of the block
// assumes byte addresses within local space zero, 32-bit data words
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

// controller registers
`define PIC_OFS_STATUS    8'h30
`define PIC_OFS_CLEAR     8'h34
`define PIC_OFS_OVERRUN   8'h38
// bridge and digital registers
`define PIC_OFS_CSR       8'h68
`define PIC_OFS_PORT0     8'h78
`define PIC_OFS_DCTL      8'h7c

// port 0 window selects in digital control bits 1:0
`define PIC_SEL_MASK      2'b10
`define PIC_SEL_PATTERN   2'b11

// bridge control/status bit positions
`define PIC_CSR_MBOX_EN   3
`define PIC_CSR_PCI_EN    8
`define PIC_CSR_LINT_EN   11
`define PIC_CSR_LINT_ACT  15
`define PIC_CSR_DMA1_ACT  22
`define PIC_CSR_TEST_ACT  23
`define PIC_CSR_ABT_LO    24
`define PIC_CSR_ABT_HI    27
`define PIC_CSR_MBOX_LO   28
`define PIC_CSR_MBOX_HI   31

// reset values
`define PIC_RST_SMASK     8'h00
`define PIC_RST_CMASK     8'h00
`define PIC_RST_PCI_EN    1'b1
`define PIC_RST_LINT_EN   1'b0
`define PIC_RST_ABT       4'hf
`define PIC_RST_DCTL      6'h00

// sample tick near 8 MHz derived from the 25 MHz system clock, every 3 cycles
`define PIC_CLK_NS        40
`define PIC_SAMPLE_NS     125
`define PIC_SAMPLE_CYC    (`PIC_SAMPLE_NS / `PIC_CLK_NS)

`endif

// File: logic/pic_pkg.sv
// types shared by the interrupt controller and its digital input logic
// assumes the constants header supplies all numeric values except the forwarding state encodings set here
package pic_pkg;

    // one local bus access, held for one cycle
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } pic_lbus_t;

    // digital control word, bit 5 down to bit 0
    typedef struct packed {
        logic       sample_src;   // 1 = user counter one output
        logic       enable;
        logic       match_mode;   // 1 = match, 0 = event
        logic       port1_out;
        logic [1:0] sel;
    } pic_dctl_t;

    // forwarding state
    typedef enum logic [1:0] {
        PIC_FWD_IDLE = 2'b01,
        PIC_FWD_HOLD = 2'b10
    } pic_fwd_t;

endpackage

// File: logic/pic_digirq.sv
// port 0 event and match interrupt detection with two-sample filter
// assumes port 0 lines and the counter output are synchronous to sys_clk
`timescale 1ns/1ns
`include "pic_params.svh"

module pic_digirq (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic [7:0]        port0_lines,
    input  wire logic              user_counter_one,
    input  wire pic_pkg::pic_dctl_t dctl,
    input  wire logic [7:0]        bit_mask,
    input  wire logic [7:0]        pattern,
    output logic                   dig_irq,
    output logic                   cap_valid,
    output logic [7:0]             cap_data
);

    logic [1:0] div_r,   div_nxt;
    logic       ctr_r,   ctr_nxt;
    logic [7:0] smp_r,   smp_nxt;
    logic [7:0] flt_r,   flt_nxt;
    logic       hit_r,   hit_nxt;
    logic       irq_r,   irq_nxt;
    logic       cap_r,   cap_nxt;
    logic [7:0] cdat_r,  cdat_nxt;
    logic       tick;
    logic [7:0] stable;
    logic [7:0] chg;
    logic       match;

    ////////////////////////////////////////////////////////////////////
    // sample tick, filter and detection
    always_comb begin
        div_nxt  = (div_r == 2'(`PIC_SAMPLE_CYC - 1)) ? 2'h0 : div_r + 2'h1;
        ctr_nxt  = user_counter_one;
        // R11: sample clock choice
        tick     = dctl.sample_src ? (user_counter_one & ~ctr_r)
                                   : (div_r == 2'h0);
        smp_nxt  = smp_r;
        flt_nxt  = flt_r;
        stable   = ~(port0_lines ^ smp_r);
        hit_nxt  = hit_r;
        irq_nxt  = 1'b0;
        cap_nxt  = 1'b0;
        cdat_nxt = cdat_r;
        chg      = 8'h00;
        match    = 1'b0;
        if (tick) begin
            smp_nxt = port0_lines;
            // R15: two edges before accepted
            flt_nxt = (port0_lines & stable) | (flt_r & ~stable);
            // R13: masked bits take no part
            chg     = (flt_nxt ^ flt_r) & ~bit_mask;
            // R14: all unmasked lines equal pattern
            match   = ((flt_nxt ^ pattern) & ~bit_mask) == 8'h00;
            hit_nxt = match;
            if (dctl.enable && !dctl.match_mode && chg != 8'h00) begin
                // R11: event raises and latches pattern
                irq_nxt  = 1'b1;
                cap_nxt  = 1'b1;
                cdat_nxt = flt_nxt;
            end
            // level match would flood the controller, so only its rise
            if (dctl.enable && dctl.match_mode && match && !hit_r) begin
                irq_nxt = 1'b1;
            end
        end
    end

    // state registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            div_r  <= 2'h0;
            ctr_r  <= 1'b0;
            smp_r  <= 8'h00;
            flt_r  <= 8'h00;
            hit_r  <= 1'b0;
            irq_r  <= 1'b0;
            cap_r  <= 1'b0;
            cdat_r <= 8'h00;
        end else begin
            div_r  <= div_nxt;
            ctr_r  <= ctr_nxt;
            smp_r  <= smp_nxt;
            flt_r  <= flt_nxt;
            hit_r  <= hit_nxt;
            irq_r  <= irq_nxt;
            cap_r  <= cap_nxt;
            cdat_r <= cdat_nxt;
        end
    end

    assign dig_irq   = irq_r;
    assign cap_valid = cap_r;
    assign cap_data  = cdat_r;

    ////////////////////////////////////////////////////////////////////
    // R10: no interrupt while disabled
    dig_enable_a: assert property ( // R10
        @(posedge sys_clk) disable iff (!rst_b)
        (!dctl.enable) |=> !irq_r)
        else $error("digital irq raised while disabled");

    // R11: capture holds the filtered pattern
    event_cap_a: assert property ( // R11
        @(posedge sys_clk) disable iff (!rst_b)
        cap_r |-> (cdat_r == flt_r) && irq_r)
        else $error("event capture differs from filtered lines");

    // R15: a changed bit matched the last two samples
    filter_two_a: assert property ( // R15
        @(posedge sys_clk) disable iff (!rst_b)
        (flt_r != $past(flt_r))
        |-> (((flt_r ^ smp_r) & (flt_r ^ $past(flt_r))) == 8'h00
             && ((flt_r ^ $past(smp_r)) & (flt_r ^ $past(flt_r)))
                == 8'h00))
        else $error("filter accepted a single sample");

endmodule // pic_digirq

// File: logic/pic_top.sv
// priority interrupt controller, bridge status bits and digital control
// assumes one-cycle read/write strobes on the local bus, read data a
// cycle later, and source requests given as one-cycle pulses
//
// Operation
// R01: all sources disabled after reset
// R02: software clears, dummy-reads, then writes mask
// R03: clear read drops requests under clear mask
// R04: only mask-enabled sources may request
// R05: forward one pending request at a time
// R06: status shows one bit, the forwarded one
// R07: repeat before clearing sets overrun bit
// R08: service reads bridge, status, then clears
// R09: controller registers at 030h to 038h
// R10: control bit 3 mode, bit 4 enable
// R11: event mode samples, interrupts, latches pattern
// R12: select 11 reaches pattern latch
// R13: select 10 reaches bit mask
// R14: match mode interrupts on unmasked equality
// R15: change must persist two sample edges
// R16: bit 22 shows DMA channel 1 interrupt
// R17: bit 23 follows self-test request bit
// R18: bits 24-26 reset one, zero names abort owner
// R19: bit 27 zero after retry-limit abort
// R20: bits 28-31 flag mailbox writes when enabled
// R21: PCI interrupt while local input low, enabled
// R22: clearing request releases local interrupt input
// R23: lowest source position wins priority
// R24: status held until its request cleared
`timescale 1ns/1ns
`include "pic_params.svh"

module pic_top (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire pic_pkg::pic_lbus_t lbus,
    input  wire logic [6:0]        board_src_req,
    input  wire logic [7:0]        port0_lines,
    input  wire logic              user_counter_one,
    input  wire logic              dma1_irq_active,
    input  wire logic              self_test_request,
    input  wire logic              abort_pulse,
    input  wire logic [1:0]        abort_owner,
    input  wire logic              retry_abort_pulse,
    input  wire logic [3:0]        mailbox_write,
    input  wire logic [3:0]        mailbox_read,
    output logic [31:0]            rd_data,
    output logic                   local_irq_in_n,
    output logic                   pci_irq_n
);

    logic [7:0]         smask_r,  smask_nxt;
    logic [7:0]         cmask_r,  cmask_nxt;
    logic [7:0]         pend_r,   pend_nxt;
    logic [7:0]         ovr_r,    ovr_nxt;
    logic [7:0]         stat_r,   stat_nxt;
    pic_pkg::pic_fwd_t  fst_r,    fst_nxt;
    logic               lirq_n_r, lirq_n_nxt;
    logic               pirq_n_r, pirq_n_nxt;
    logic               mben_r,   mben_nxt;
    logic               pcien_r,  pcien_nxt;
    logic               linten_r, linten_nxt;
    logic               dma1_r,   dma1_nxt;
    logic               test_r,   test_nxt;
    logic [3:0]         abt_r,    abt_nxt;
    logic [3:0]         mbox_r,   mbox_nxt;
    pic_pkg::pic_dctl_t dctl_r,   dctl_nxt;
    logic [7:0]         bmask_r,  bmask_nxt;
    logic [7:0]         patt_r,   patt_nxt;
    logic [31:0]        rdat_r,   rdat_nxt;
    logic [7:0]         src;
    logic [7:0]         req;
    logic [7:0]         clr;
    logic [7:0]         ovr_w1c;
    logic [31:0]        csr;
    logic               dig_irq;
    logic               cap_valid;
    logic [7:0]         cap_data;

    ////////////////////////////////////////////////////////////////////
    // port 0 digital interrupt source, feeds position 0
    pic_digirq u_digirq (
        .sys_clk          (sys_clk),
        .rst_b            (rst_b),
        .port0_lines      (port0_lines),
        .user_counter_one (user_counter_one),
        .dctl             (dctl_r),
        .bit_mask         (bmask_r),
        .pattern          (patt_r),
        .dig_irq          (dig_irq),
        .cap_valid        (cap_valid),
        .cap_data         (cap_data)
    );

    assign src = {board_src_req, dig_irq};

    ////////////////////////////////////////////////////////////////////
    // priority controller next state
    always_comb begin
        // R04: masked sources ignored
        req      = src & smask_r;
        // R03: clear read discards masked requests
        clr      = (lbus.rd && lbus.addr == `PIC_OFS_CLEAR) ? cmask_r : 8'h00;
        ovr_w1c  = (lbus.wr && lbus.addr == `PIC_OFS_OVERRUN)
                   ? lbus.wdata[7:0] : 8'h00;
        // a request in the clearing cycle survives: set beats clear
        pend_nxt = (pend_r & ~clr) | req;
        // R07: request again while still pending
        ovr_nxt  = (ovr_r & ~ovr_w1c) | (req & pend_r);
        // R01: mask stays zero until written
        smask_nxt = (lbus.wr && lbus.addr == `PIC_OFS_STATUS)
                    ? lbus.wdata[7:0] : smask_r;
        cmask_nxt = (lbus.wr && lbus.addr == `PIC_OFS_CLEAR)
                    ? lbus.wdata[7:0] : cmask_r;
        stat_nxt = stat_r;
        fst_nxt  = fst_r;
        case (fst_r)
            pic_pkg::PIC_FWD_IDLE: begin
                // a request discarded by this cycle's clear read is skipped
                if ((pend_r & ~clr) != 8'h00) begin
                    // R05: one request forwarded at a time
                    // R23: lowest position has priority
                    stat_nxt = (pend_r & ~clr) & (~(pend_r & ~clr) + 8'h01);
                    fst_nxt  = pic_pkg::PIC_FWD_HOLD;
                end
            end
            pic_pkg::PIC_FWD_HOLD: begin
                // R24: hold until the forwarded request clears
                if ((stat_r & clr) != 8'h00) begin
                    stat_nxt = 8'h00;
                    fst_nxt  = pic_pkg::PIC_FWD_IDLE;
                end
            end
            default: begin
                stat_nxt = 8'h00;
                fst_nxt  = pic_pkg::PIC_FWD_IDLE;
            end
        endcase
        // R22: released once nothing is forwarded
        lirq_n_nxt = ~(|stat_nxt);
        // R21: level follows local input and enables
        pirq_n_nxt = ~(pcien_r & linten_r & ~lirq_n_r);
    end

    ////////////////////////////////////////////////////////////////////
    // bridge status and digital control next state
    always_comb begin
        mben_nxt   = mben_r;
        pcien_nxt  = pcien_r;
        linten_nxt = linten_r;
        if (lbus.wr && lbus.addr == `PIC_OFS_CSR) begin
            mben_nxt   = lbus.wdata[`PIC_CSR_MBOX_EN];
            pcien_nxt  = lbus.wdata[`PIC_CSR_PCI_EN];
            linten_nxt = lbus.wdata[`PIC_CSR_LINT_EN];
        end
        // R16: live DMA channel 1 flag
        dma1_nxt = dma1_irq_active;
        // R17: follows the self-test request bit
        test_nxt = self_test_request;
        // R18: zero marks the bus owner at abort
        abt_nxt  = abt_r;
        if (abort_pulse) begin
            abt_nxt[2:0] = ~(3'b001 << abort_owner);
            abt_nxt[3]   = 1'b1;
        end
        // R19: retry-limit abort clears bit 27
        if (retry_abort_pulse) begin
            abt_nxt[3] = 1'b0;
        end
        // R20: mailbox flags only while enabled, set beats clear
        mbox_nxt = (mbox_r & ~mailbox_read) | (mailbox_write & {4{mben_r}});
        // R10: mode and enable bits held here
        dctl_nxt  = dctl_r;
        bmask_nxt = bmask_r;
        patt_nxt  = patt_r;
        if (lbus.wr && lbus.addr == `PIC_OFS_DCTL) begin
            dctl_nxt = pic_pkg::pic_dctl_t'(lbus.wdata[5:0]);
        end
        // R13: select 10 writes the bit mask
        if (lbus.wr && lbus.addr == `PIC_OFS_PORT0
            && dctl_r.sel == `PIC_SEL_MASK) begin
            bmask_nxt = lbus.wdata[7:0];
        end
        // R12: select 11 writes the pattern latch
        if (lbus.wr && lbus.addr == `PIC_OFS_PORT0
            && dctl_r.sel == `PIC_SEL_PATTERN) begin
            patt_nxt = lbus.wdata[7:0];
        end
        // capture wins over a software write in the same cycle
        if (cap_valid) begin
            patt_nxt = cap_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe
    always_comb begin
        csr = 32'h0000_0000;
        csr[`PIC_CSR_MBOX_EN]  = mben_r;
        csr[`PIC_CSR_PCI_EN]   = pcien_r;
        csr[`PIC_CSR_LINT_EN]  = linten_r;
        csr[`PIC_CSR_LINT_ACT] = ~lirq_n_r;
        csr[`PIC_CSR_DMA1_ACT] = dma1_r;
        csr[`PIC_CSR_TEST_ACT] = test_r;
        csr[`PIC_CSR_ABT_HI:`PIC_CSR_ABT_LO]   = abt_r;
        csr[`PIC_CSR_MBOX_HI:`PIC_CSR_MBOX_LO] = mbox_r;
        rdat_nxt = 32'h0000_0000;
        // R09: controller registers at 030h to 038h
        if (!lbus.rd) begin
            rdat_nxt = rdat_r;
        end else if (lbus.addr == `PIC_OFS_STATUS) begin
            // R06: one-hot forwarded source
            rdat_nxt = {24'h00_0000, stat_r};
        end else if (lbus.addr == `PIC_OFS_CLEAR) begin
            rdat_nxt = {24'h00_0000, stat_r};
        end else if (lbus.addr == `PIC_OFS_OVERRUN) begin
            rdat_nxt = {24'h00_0000, ovr_r};
        end else if (lbus.addr == `PIC_OFS_CSR) begin
            rdat_nxt = csr;
        end else if (lbus.addr == `PIC_OFS_PORT0
                     && dctl_r.sel == `PIC_SEL_MASK) begin
            rdat_nxt = {24'h00_0000, bmask_r};
        end else if (lbus.addr == `PIC_OFS_PORT0
                     && dctl_r.sel == `PIC_SEL_PATTERN) begin
            rdat_nxt = {24'h00_0000, patt_r};
        end else if (lbus.addr == `PIC_OFS_DCTL) begin
            rdat_nxt = {26'h000_0000, dctl_r};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // all state registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            smask_r  <= `PIC_RST_SMASK;
            cmask_r  <= `PIC_RST_CMASK;
            pend_r   <= 8'h00;
            ovr_r    <= 8'h00;
            stat_r   <= 8'h00;
            fst_r    <= pic_pkg::PIC_FWD_IDLE;
            lirq_n_r <= 1'b1;
            pirq_n_r <= 1'b1;
            mben_r   <= 1'b0;
            pcien_r  <= `PIC_RST_PCI_EN;
            linten_r <= `PIC_RST_LINT_EN;
            dma1_r   <= 1'b0;
            test_r   <= 1'b0;
            abt_r    <= `PIC_RST_ABT;
            mbox_r   <= 4'h0;
            dctl_r   <= pic_pkg::pic_dctl_t'(`PIC_RST_DCTL);
            bmask_r  <= 8'h00;
            patt_r   <= 8'h00;
            rdat_r   <= 32'h0000_0000;
        end else begin
            smask_r  <= smask_nxt;
            cmask_r  <= cmask_nxt;
            pend_r   <= pend_nxt;
            ovr_r    <= ovr_nxt;
            stat_r   <= stat_nxt;
            fst_r    <= fst_nxt;
            lirq_n_r <= lirq_n_nxt;
            pirq_n_r <= pirq_n_nxt;
            mben_r   <= mben_nxt;
            pcien_r  <= pcien_nxt;
            linten_r <= linten_nxt;
            dma1_r   <= dma1_nxt;
            test_r   <= test_nxt;
            abt_r    <= abt_nxt;
            mbox_r   <= mbox_nxt;
            dctl_r   <= dctl_nxt;
            bmask_r  <= bmask_nxt;
            patt_r   <= patt_nxt;
            rdat_r   <= rdat_nxt;
        end
    end

    assign rd_data        = rdat_r;
    assign local_irq_in_n = lirq_n_r;
    assign pci_irq_n      = pirq_n_r;

    ////////////////////////////////////////////////////////////////////
    // R01: mask is zero just after reset
    mask_reset_a: assert property ( // R01
        @(posedge sys_clk) disable iff (!rst_b)
        !$past(rst_b) |-> (smask_r == 8'h00))
        else $error("source mask not cleared by reset");

    // R03: masked pending bits gone after clear read
    clear_read_a: assert property ( // R03
        @(posedge sys_clk) disable iff (!rst_b)
        (clr != 8'h00) |=> ((pend_r & $past(clr) & ~$past(req)) == 8'h00))
        else $error("clear read left a masked request pending");

    // R04: new pending bits only where enabled
    mask_gate_a: assert property ( // R04
        @(posedge sys_clk) disable iff (!rst_b)
        1'b1 |=> ((pend_r & ~$past(pend_r) & ~$past(smask_r)) == 8'h00))
        else $error("masked source became pending");

    // R06: exactly one status bit while forwarding
    one_hot_a: assert property ( // R06
        @(posedge sys_clk) disable iff (!rst_b)
        (fst_r == pic_pkg::PIC_FWD_HOLD) |-> $onehot(stat_r)
                                             && ((stat_r & ~pend_r) == 8'h00
                                                 || clr != 8'h00))
        else $error("status not one-hot while forwarding");

    // R07: overrun set on repeated request
    overrun_set_a: assert property ( // R07
        @(posedge sys_clk) disable iff (!rst_b)
        ((req & pend_r) != 8'h00) |=> ((ovr_r & $past(req & pend_r))
                                       == $past(req & pend_r)))
        else $error("overrun bit missed");

    // R21: PCI interrupt follows local input
    pci_follow_a: assert property ( // R21
        @(posedge sys_clk) disable iff (!rst_b)
        (!lirq_n_r && pcien_r && linten_r) |=> !pci_irq_n)
        else $error("PCI interrupt not asserted");

    // R22: local input released after clearing
    lint_release_a: assert property ( // R22
        @(posedge sys_clk) disable iff (!rst_b)
        (fst_r == pic_pkg::PIC_FWD_HOLD && (stat_r & clr) != 8'h00)
        |=> lirq_n_r ##1 (lirq_n_r || $onehot(stat_r)))
        else $error("local interrupt not released");

    // R23: lowest pending position chosen
    prio_low_a: assert property ( // R23
        @(posedge sys_clk) disable iff (!rst_b)
        (fst_r == pic_pkg::PIC_FWD_IDLE && (pend_r & ~clr) != 8'h00)
        |=> (stat_r == ($past(pend_r & ~clr)
                        & (~$past(pend_r & ~clr) + 8'h01))))
        else $error("forwarded request is not the lowest");

    // R24: status stable until cleared
    hold_stat_a: assert property ( // R24
        @(posedge sys_clk) disable iff (!rst_b)
        (fst_r == pic_pkg::PIC_FWD_HOLD && (stat_r & clr) == 8'h00)
        |=> $stable(stat_r))
        else $error("status moved before clear");

endmodule // pic_top

// File: tb/pic_host_model.sv
// host model: counts interrupt entries seen on the PCI line
// assumes pci_irq_n is registered on sys_clk
`timescale 1ns/1ns
module pic_host_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       pci_irq_n,
    output logic [7:0]      irq_count
);
    logic prev_r;
    ////////////////////////////////////////////////////////////////////
    // service pass entry
    // each falling edge starts one service pass of the host
    always_ff @(posedge sys_clk) begin
        prev_r <= pci_irq_n;
        if (!rst_b) begin
            irq_count <= 8'h00;
            prev_r    <= 1'b1;
        end else if (prev_r && !pci_irq_n) begin
            irq_count <= irq_count + 8'h01;
        end
    end
endmodule // pic_host_model

// File: tb/tb_top.sv
// bench for the interrupt controller: register tasks and scenarios
// assumes one-cycle strobes, read data taken one cycle after the read
`timescale 1ns/1ns
module tb_top;
    logic               sys_clk = 1'b0;
    logic               rst_b   = 1'b0;
    pic_pkg::pic_lbus_t lbus    = '0;
    logic [6:0]         src     = 7'h00;
    logic [7:0]         p0      = 8'h00;
    logic [2:0]         ucnt    = 3'h0;
    logic               dma1    = 1'b0;
    logic               tst     = 1'b0;
    logic               abt     = 1'b0;
    logic [1:0]         own     = 2'h0;
    logic               rty     = 1'b0;
    logic [3:0]         mbw     = 4'h0;
    logic [3:0]         mbr     = 4'h0;
    logic [31:0]        rdat;
    logic               lirq_n;
    logic               pirq_n;
    logic [7:0]         nirq;
    logic [31:0]        d;
    int                 n_fail  = 0;
    int                 n_tests = 0;

    always #20 sys_clk = ~sys_clk;
    // counter output toggles every 4 cycles as an alternate sample tick
    always @(posedge sys_clk) ucnt <= #1 ucnt + 3'h1;

    pic_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .lbus(lbus),
        .board_src_req(src), .port0_lines(p0),
        .user_counter_one(ucnt[2]), .dma1_irq_active(dma1),
        .self_test_request(tst), .abort_pulse(abt), .abort_owner(own),
        .retry_abort_pulse(rty), .mailbox_write(mbw),
        .mailbox_read(mbr), .rd_data(rdat), .local_irq_in_n(lirq_n),
        .pci_irq_n(pirq_n));
    pic_host_model u_host (.sys_clk(sys_clk), .rst_b(rst_b),
        .pci_irq_n(pirq_n), .irq_count(nirq));

    ////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // every drive lands 1 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        cyc(1);
        lbus = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
        cyc(1);
        lbus.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        cyc(1);
        lbus = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
        cyc(1);
        lbus.rd = 1'b0;
        cyc(1);
        d = rdat;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask
    // bounded wait for the forwarded request
    task automatic wirq();
        int i;
        i = 0;
        while (lirq_n !== 1'b0 && i < 60) begin
            cyc(1);
            i++;
        end
        chk({31'h0, lirq_n}, 32'h0);
        if (i == 60)
            test_done();
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        cyc(20000);
        n_fail++;
        test_done();
    end

    initial begin
        cyc(10);
        rst_b = 1'b1;
        rc(8'h30, 32'h0);
        rc(8'h68, 32'h0f000100);
        src = 7'h01;
        cyc(1);
        src = 7'h00;
        rc(8'h30, 32'h0);
        rc(8'h3c, 32'h0);
        wr(8'h34, 32'hff);
        rd(8'h34);
        wr(8'h30, 32'hfe);
        wr(8'h68, 32'h900);
        // sources 1 and 3 together, then source 1 again while pending
        src = 7'h05;
        cyc(1);
        src = 7'h01;
        cyc(1);
        src = 7'h00;
        wirq();
        cyc(1);
        chk({31'h0, pirq_n}, 32'h0);
        rc(8'h68, 32'h0f008900);
        chk({24'h0, nirq}, 32'h1);
        rc(8'h30, 32'h02);
        rc(8'h38, 32'h02);
        wr(8'h34, 32'h02);
        rc(8'h34, 32'h02);
        rc(8'h30, 32'h08);
        wr(8'h34, 32'h08);
        rc(8'h34, 32'h08);
        chk({31'h0, lirq_n}, 32'h1);
        chk({31'h0, pirq_n}, 32'h1);
        wr(8'h38, 32'h02);
        rc(8'h38, 32'h0);
        // event mode: glitch and masked change must not interrupt
        wr(8'h7c, 32'h02);
        wr(8'h78, 32'h0f);
        rc(8'h78, 32'h0f);
        wr(8'h7c, 32'h13);
        wr(8'h30, 32'hff);
        p0 = 8'h42;
        cyc(1);
        p0 = 8'h02;
        cyc(20);
        rc(8'h30, 32'h0);
        p0 = 8'h22;
        wirq();
        rc(8'h30, 32'h01);
        rc(8'h78, 32'h22);
        wr(8'h34, 32'h01);
        rd(8'h34);
        // match mode on counter ticks, low nibble masked
        wr(8'h78, 32'ha0);
        wr(8'h7c, 32'h3b);
        rc(8'h7c, 32'h3b);
        p0 = 8'ha5;
        wirq();
        rc(8'h30, 32'h01);
        wr(8'h34, 32'h01);
        rd(8'h34);
        wr(8'h7c, 32'h00);
        rc(8'h78, 32'h0);
        // bridge status flags
        dma1 = 1'b1;
        tst = 1'b1;
        abt = 1'b1;
        own = 2'h1;
        mbw = 4'h4;
        cyc(1);
        abt = 1'b0;
        mbw = 4'h0;
        rc(8'h68, 32'h0dc00900);
        wr(8'h68, 32'h908);
        mbw = 4'h4;
        rty = 1'b1;
        cyc(1);
        mbw = 4'h0;
        rty = 1'b0;
        rc(8'h68, 32'h45c00908);
        mbr = 4'h4;
        dma1 = 1'b0;
        tst = 1'b0;
        cyc(1);
        mbr = 4'h0;
        rc(8'h68, 32'h05000908);
        chk({24'h0, nirq}, 32'h4);
        test_done();
    end
endmodule // tb_top
